// *** hdl/sss_pkg.sv ***
// Shared constants, state encoding and helpers for the sensor serial slave.
package sss_pkg;

   localparam int         ADDR_W      = 7;
   localparam int         DATA_W      = 8;

   // Bit positions inside the frame header byte.
   localparam int         HDR_RW_POS  = 7;
   localparam int         HDR_ADDR_HI = 6;

   localparam logic [2:0] BIT_FIRST   = 3'h0;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [6:0] ADDR_RST    = 7'h00;
   localparam logic [6:0] ADDR_STEP   = 7'h01;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [7:0] DUMMY_BYTE  = 8'h00;

   localparam logic       RW_WRITE    = 1'b0;
   localparam logic       RW_READ     = 1'b1;

   // Reset values of the pin synchronisers: chip select idles high.
   localparam logic       CS_RST      = 1'b1;
   localparam logic       SCK_RST     = 1'b0;
   localparam logic       SDX_RST     = 1'b0;

   // Idle gaps the master has to keep, in their own units.
   localparam int         CLK_PERIOD_PS   = 25000;
   localparam int         IDLE_ACT_US     = 2;
   localparam int         IDLE_SUSP_US    = 1000;
   localparam int         IDLE_ACT_CYCLES = (IDLE_ACT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_HEADER = 4'b0010,
      ST_WRITE  = 4'b0100,
      ST_READ   = 4'b1000
   } sss_state_t;

   // Shifts a byte one place towards the most significant end.
   function automatic logic [7:0] sss_shl(input logic [7:0] sr, input logic b);
      return {sr[6:0], b};
   endfunction : sss_shl

endpackage : sss_pkg

// *** hdl/sss_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
`default_nettype none

module sss_pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic s1;
   logic s2;
   logic s3;
   logic lvl;
   logic lvl_d;

   // The first stage feeds the second stage only; the level moves once stages two and three agree.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1    <= RST_VAL;
         s2    <= RST_VAL;
         s3    <= RST_VAL;
         lvl   <= RST_VAL;
         lvl_d <= RST_VAL;
      end else begin
         s1    <= pin;
         s2    <= s1;
         s3    <= s2;
         lvl   <= (s2 == s3) ? s3 : lvl;
         lvl_d <= lvl;
      end
   end

   assign level = lvl;
   assign rise  = lvl & ~lvl_d;
   assign fall  = ~lvl & lvl_d;

endmodule : sss_pin_sync

`default_nettype wire

// *** hdl/sss_proto_sel.sv ***
// Primary interface protocol choice between two-wire serial and SPI.
`timescale 1ns/1ps
`default_nettype none

module sss_proto_sel (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic cs_rise,
   input  wire logic nv_spi_en,
   output logic      spi_active
);

   logic spi_sel;

   // Only reset clears the choice, so a selection made once holds until the next reset.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         spi_sel <= 1'b0;
      end else if (cs_rise || nv_spi_en) begin
         spi_sel <= 1'b1;
      end
   end

   assign spi_active = spi_sel;

endmodule : sss_proto_sel

`default_nettype wire

// *** hdl/sss_spi_slave.sv ***
// SPI slave front end of the sensor's primary interface, with protocol selection.
// The pins are oversampled, so the serial clock must stay well below a quarter of mclk.
`timescale 1ns/1ps
`default_nettype none

module sss_spi_slave (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       chip_select_low_n,
   input  wire logic       sck,
   input  wire logic       sdi_in,
   output logic            sdi_out,
   output logic            sdi_oe,
   output logic            sdo_out,
   output logic            sdo_oe,
   input  wire logic       three_wire_select,
   input  wire logic       nv_spi_en,
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   output logic            spi_active,
   output logic            spi_mode_11,
   output logic            frame_busy
);

   // Synchronised pins.
   logic cs_rise;
   logic cs_fall;
   logic sck_lvl;
   logic sck_rise;
   logic sdx_lvl;

   // Decoded frame events.
   logic       in_idle;
   logic       in_header;
   logic       in_write;
   logic       in_read;
   logic       frame_start;
   logic       frame_end;
   logic       byte_last;
   logic [7:0] rx_next;
   logic       hdr_done;
   logic       hdr_is_read;
   logic [6:0] hdr_addr;
   logic       wr_fire;
   logic       rd_start;
   logic       rd_next;
   logic [6:0] addr_inc;

   // Frame state.
   sss_pkg::sss_state_t state;
   sss_pkg::sss_state_t next_state;
   logic [2:0]          bit_cnt;
   logic [7:0]          rx_sr;
   logic [7:0]          tx_sr;
   logic [7:0]          rd_hold;
   logic [6:0]          addr_ptr;
   logic                tw_frame;
   logic                cpol;
   logic                drive_on;
   logic                sdo_bit;
   logic                wr_q;
   logic                rd_q;
   logic [6:0]          addr_q;
   logic [7:0]          wdata_q;

   sss_pin_sync #(
      .RST_VAL (sss_pkg::CS_RST)
   ) u_cs_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (chip_select_low_n),
      .level (),
      .rise  (cs_rise),
      .fall  (cs_fall)
   );

   sss_pin_sync #(
      .RST_VAL (sss_pkg::SCK_RST)
   ) u_sck_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (sck),
      .level (sck_lvl),
      .rise  (sck_rise),
      .fall  ()
   );

   // The data pin is the same pin in both wirings, so one synchroniser serves both.
   sss_pin_sync #(
      .RST_VAL (sss_pkg::SDX_RST)
   ) u_sdx_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (sdi_in),
      .level (sdx_lvl),
      .rise  (),
      .fall  ()
   );

   sss_proto_sel u_proto_sel (
      .mclk       (mclk),
      .rst        (rst),
      .cs_rise    (cs_rise),
      .nv_spi_en  (nv_spi_en),
      .spi_active (spi_active)
   );

   // Decoding of frame events.
   assign in_idle     = (state == sss_pkg::ST_IDLE);
   assign in_header   = (state == sss_pkg::ST_HEADER);
   assign in_write    = (state == sss_pkg::ST_WRITE);
   assign in_read     = (state == sss_pkg::ST_READ);
   assign frame_start = in_idle & cs_fall & spi_active;
   assign frame_end   = ~in_idle & cs_rise;
   assign byte_last   = sck_rise & (bit_cnt == sss_pkg::BIT_LAST);
   assign rx_next     = sss_pkg::sss_shl(rx_sr, sdx_lvl);
   assign hdr_done    = in_header & byte_last & ~cs_rise;
   assign hdr_is_read = (rx_next[sss_pkg::HDR_RW_POS] == sss_pkg::RW_READ);
   assign hdr_addr    = rx_next[sss_pkg::HDR_ADDR_HI:0];
   assign wr_fire     = in_write & byte_last & ~cs_rise;
   assign rd_start    = hdr_done & hdr_is_read;
   assign rd_next     = in_read & byte_last & ~cs_rise;
   assign addr_inc    = addr_ptr + sss_pkg::ADDR_STEP;

   // Frame sequencing.
   always_comb begin
      next_state = state;
      unique case (state)
         sss_pkg::ST_IDLE: begin
            if (frame_start) begin
               next_state = sss_pkg::ST_HEADER;
            end
         end
         sss_pkg::ST_HEADER: begin
            if (frame_end) begin
               next_state = sss_pkg::ST_IDLE;
            end else if (hdr_done) begin
               next_state = hdr_is_read ? sss_pkg::ST_READ : sss_pkg::ST_WRITE;
            end
         end
         sss_pkg::ST_WRITE: begin
            if (frame_end) begin
               next_state = sss_pkg::ST_IDLE;
            end
         end
         sss_pkg::ST_READ: begin
            if (frame_end) begin
               next_state = sss_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = sss_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= sss_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Mode is latched when the frame opens so it stays steady for its length.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpol <= 1'b0;
      end else if (frame_start) begin
         cpol <= sck_lvl;
      end
   end

   // A write that changes the wiring only takes effect from the next frame.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tw_frame <= 1'b0;
      end else if (frame_start) begin
         tw_frame <= three_wire_select;
      end
   end

   // Both modes sample on the rising clock edge, so one receive path serves them.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bit_cnt <= sss_pkg::BIT_FIRST;
      end else if (frame_start) begin
         bit_cnt <= sss_pkg::BIT_FIRST;
      end else if (!in_idle && sck_rise) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_sr <= sss_pkg::BYTE_RST;
      end else if (frame_start) begin
         rx_sr <= sss_pkg::BYTE_RST;
      end else if (!in_idle && sck_rise) begin
         rx_sr <= rx_next;
      end
   end

   // The address steps after each byte written or returned.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_ptr <= sss_pkg::ADDR_RST;
      end else if (hdr_done) begin
         addr_ptr <= hdr_addr;
      end else if (wr_fire) begin
         addr_ptr <= addr_inc;
      end else if (rd_next) begin
         addr_ptr <= addr_inc;
      end
   end

   // Write strobe and data come straight from flip-flops.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_q    <= 1'b0;
         wdata_q <= sss_pkg::BYTE_RST;
      end else begin
         wr_q <= wr_fire;
         if (wr_fire) begin
            wdata_q <= rx_next;
         end
      end
   end

   // Read strobe, one cycle long, so the register side fetches each byte once.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_q <= 1'b0;
      end else begin
         rd_q <= rd_start | rd_next;
      end
   end

   // The port address follows whichever strobe is about to fire.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_q <= sss_pkg::ADDR_RST;
      end else if (wr_fire) begin
         addr_q <= addr_ptr;
      end else if (rd_start) begin
         addr_q <= hdr_addr;
      end else if (rd_next) begin
         addr_q <= addr_inc;
      end
   end

   // The fetched byte waits here while the previous byte is still going out.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_hold <= sss_pkg::BYTE_RST;
      end else if (rd_q) begin
         rd_hold <= reg_rdata;
      end
   end

   // A new output bit appears one mclk cycle after the detected rising edge, so the line
   // changes about five mclk cycles after the pin's rising edge and holds through the master's next sampling edge.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sdo_bit <= 1'b0;
      end else if (rd_start) begin
         sdo_bit <= sss_pkg::DUMMY_BYTE[7];
      end else if (rd_next) begin
         sdo_bit <= rd_hold[7];
      end else if (in_read && sck_rise) begin
         sdo_bit <= tx_sr[7];
      end
   end

   // The shift register holds the bits still to come, one place ahead of the pin.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_sr <= sss_pkg::BYTE_RST;
      end else if (rd_start) begin
         tx_sr <= sss_pkg::sss_shl(sss_pkg::DUMMY_BYTE, 1'b0);
      end else if (rd_next) begin
         tx_sr <= sss_pkg::sss_shl(rd_hold, 1'b0);
      end else if (in_read && sck_rise) begin
         tx_sr <= sss_pkg::sss_shl(tx_sr, 1'b0);
      end
   end

   // Drive starts with the first bit of the dummy byte after a read header and ends when the frame closes.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         drive_on <= 1'b0;
      end else if (frame_end || in_idle) begin
         drive_on <= 1'b0;
      end else if (rd_start) begin
         drive_on <= 1'b1;
      end
   end

   assign sdo_out     = sdo_bit;
   assign sdo_oe      = drive_on & ~tw_frame;
   assign sdi_out     = sdo_bit;
   assign sdi_oe      = drive_on & tw_frame;
   assign reg_addr    = addr_q;
   assign reg_wdata   = wdata_q;
   assign reg_wr      = wr_q;
   assign reg_rd      = rd_q;
   assign spi_mode_11 = cpol;
   assign frame_busy  = ~in_idle;

endmodule : sss_spi_slave

`default_nettype wire

// *** testbench/sss_spi_slave_sva.sv ***
// Assertion checker on the serial slave's ports.
`timescale 1ns/1ps
`default_nettype none
module sss_spi_slave_sva (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       chip_select_low_n,
   input wire logic       sck,
   input wire logic       sdi_oe,
   input wire logic       sdo_oe,
   input wire logic       three_wire_select,
   input wire logic       nv_spi_en,
   input wire logic [6:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       spi_active,
   input wire logic       spi_mode_11,
   input wire logic       frame_busy
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic       seen;
   logic [6:0] prev_a;
   // A new frame starts afresh, so only strobes inside one selection are compared.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seen   <= 1'b0;
         prev_a <= 7'h00;
      end else if (!frame_busy) begin
         seen <= 1'b0;
      end else if (reg_wr || reg_rd) begin
         seen   <= 1'b1;
         prev_a <= reg_addr;
      end
   end
   property p_idle; !spi_active |-> !frame_busy && !sdo_oe && !sdi_oe; endproperty
   a_idle: assert property (p_idle) else $error("frame activity before selection");
   property p_stick; spi_active |=> spi_active; endproperty
   a_stick: assert property (p_stick) else $error("selection lost");
   property p_edge; $rose(chip_select_low_n) |-> ##[1:8] spi_active; endproperty
   a_edge: assert property (p_edge) else $error("rising select did not pick serial");
   property p_nv; nv_spi_en |-> ##[1:2] spi_active; endproperty
   a_nv: assert property (p_nv) else $error("enable bit did not pick serial");
   property p_mode; $rose(frame_busy) |=> spi_mode_11 == sck; endproperty
   a_mode: assert property (p_mode) else $error("mode not taken from clock level");
   property p_four; sdo_oe |-> !three_wire_select && !sdi_oe; endproperty
   a_four: assert property (p_four) else $error("output pin used in three-wire");
   property p_three; sdi_oe |-> three_wire_select; endproperty
   a_three: assert property (p_three) else $error("shared line driven in four-wire");
   property p_wrq; reg_wr |-> !sdo_oe && !sdi_oe; endproperty
   a_wrq: assert property (p_wrq) else $error("drive during write");
   property p_gap; (reg_wr || reg_rd) |=> (!reg_wr && !reg_rd) [*8]; endproperty
   a_gap: assert property (p_gap) else $error("strobes too close");
   property p_step; (reg_wr || reg_rd) && seen |-> reg_addr == prev_a + 7'h01; endproperty
   a_step: assert property (p_step) else $error("burst address not stepped");
   property p_start; $fell(chip_select_low_n) && spi_active |-> ##[2:8] frame_busy; endproperty
   a_start: assert property (p_start) else $error("frame not opened");
endmodule : sss_spi_slave_sva
bind sss_spi_slave sss_spi_slave_sva u_sva (.mclk(mclk), .rst(rst), .chip_select_low_n(chip_select_low_n),
   .sck(sck), .sdi_oe(sdi_oe), .sdo_oe(sdo_oe), .three_wire_select(three_wire_select), .nv_spi_en(nv_spi_en),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .spi_active(spi_active),
   .spi_mode_11(spi_mode_11), .frame_busy(frame_busy));
`default_nettype wire

// *** testbench/sss_host_model.sv ***
// Behavioural host master that frames transfers for the serial slave.
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
   input  wire logic mclk,
   input  wire logic mode_11,
   input  wire logic three_w,
   input  wire logic miso,
   output logic      cs_n,
   output logic      sck,
   output logic      mosi,
   output logic      mosi_oe
);
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   initial begin
      cs_n    = 1'b1;
      sck     = 1'b0;
      mosi    = 1'b0;
      mosi_oe = 1'b0;
   end
   // Four system clocks a level, so the slave's oversampling sees every one.
   task automatic half;
      repeat (4) @(negedge mclk);
   endtask : half
   task automatic xfer(input int n);
      int b;
      @(negedge mclk);
      sck = mode_11;
      half();
      cs_n = 1'b0;
      repeat (3) half();
      for (b = 0; b < n * 8; b++) begin
         sck     = 1'b0;
         mosi    = tx[b / 8][7 - b % 8];
         mosi_oe = !(three_w && tx[0][7] && b >= 8);
         half();
         sck                  = 1'b1;
         rx[b / 8][7 - b % 8] = miso;
         half();
      end
      sck = mode_11;
      half();
      cs_n    = 1'b1;
      mosi_oe = 1'b0;
      // The bench keeps the slave active, so the longer suspend-mode write gap never arises.
      repeat (sss_pkg::IDLE_ACT_CYCLES) @(negedge mclk);
   endtask : xfer
endmodule : sss_host_model
`default_nettype wire

// *** testbench/sss_spi_slave_tb_top.sv ***
// Self-checking bench for the serial slave: selection, modes, wiring and bursts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module sss_spi_slave_tb_top;
   logic       mclk, rst, tws, nv, mode_11, tgl, cs_n, sck, mosi, mosi_oe;
   logic       sdi_out, sdi_oe, sdo_out, sdo_oe, reg_wr, reg_rd, spi_active, spi_mode_11, frame_busy;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] mem [128];
   logic [7:0] expv [128];
   wire        sdi_line = sdi_oe ? sdi_out : (mosi_oe ? mosi : tgl);
   wire        miso = tws ? sdi_line : (sdo_oe ? sdo_out : tgl);
   int         n_errors, n_compared, cyc;
   // Any register serves for the throwaway read, since its answer is discarded.
   localparam logic [6:0] ID_ADDR = 7'h00;
   sss_host_model u_host (.mclk(mclk), .mode_11(mode_11), .three_w(tws), .miso(miso), .cs_n(cs_n),
      .sck(sck), .mosi(mosi), .mosi_oe(mosi_oe));
   sss_spi_slave u_dut (.mclk(mclk), .rst(rst), .chip_select_low_n(cs_n), .sck(sck), .sdi_in(sdi_line),
      .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .three_wire_select(tws),
      .nv_spi_en(nv), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(mem[reg_addr]), .spi_active(spi_active), .spi_mode_11(spi_mode_11), .frame_busy(frame_busy));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      tgl <= ~tgl;
      if (reg_wr) mem[reg_addr] <= reg_wdata;
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic do_reset(input logic nv_bit);
      rst = 1'b1;
      nv  = nv_bit;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : do_reset
   task automatic burst(input logic [6:0] a, input int n);
      int k;
      u_host.tx[0] = {sss_pkg::RW_WRITE, a};
      for (k = 0; k < n; k++) begin
         u_host.tx[k + 1]         = 8'($urandom);
         expv[7'(a + 7'(k))]      = u_host.tx[k + 1];
      end
      u_host.xfer(n + 1);
      for (k = 1; k < 8; k++) u_host.tx[k] = 8'h00;
      u_host.tx[0] = {sss_pkg::RW_READ, a};
      u_host.xfer(n + 2);
      `CHK(u_host.rx[1], sss_pkg::DUMMY_BYTE)
      for (k = 0; k < n; k++) `CHK(u_host.rx[k + 2], expv[7'(a + 7'(k))])
      `CHK(spi_mode_11, mode_11)
   endtask : burst
   initial begin
      int i;
      logic [6:0] a;
      tgl = 1'b0;
      tws = 1'b0;
      mode_11 = 1'b0;
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      void'($urandom(5));
      for (i = 0; i < 128; i++) mem[i] = 8'($urandom);
      expv = mem;
      do_reset(1'b0);
      repeat (20) @(negedge mclk);
      `CHK(spi_active, 1'b0)
      u_host.tx[0] = {sss_pkg::RW_READ, ID_ADDR};
      u_host.tx[1] = 8'h00;
      u_host.xfer(2);
      repeat (10) @(negedge mclk);
      `CHK(spi_active, 1'b1)
      for (i = 0; i < 8; i++) begin
         mode_11 = i[0] | i[1];
         tws = i[1];
         a = (i == 0) ? 7'h7E : 7'($urandom);
         burst(a, (i == 0) ? 4 : (i == 7) ? 1 : 1 + $urandom % 4);
         $display("test %0d done", i);
      end
      do_reset(1'b1);
      `CHK(spi_active, 1'b1)
      nv = 1'b0;
      tws = 1'b0;
      mode_11 = 1'b1;
      burst(7'h10, 2);
      $display("test nv done");
      give_verdict();
   end
endmodule : sss_spi_slave_tb_top
`default_nettype wire
